// file: verilog/amgc_consts.svh
`ifndef AMGC_CONSTS_SVH
`define AMGC_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AMGC_ADDR_AVG 8'h03
`define AMGC_ADDR_OPMODE 8'h04
`define AMGC_ADDR_FUNC 8'h05
`define AMGC_ADDR_DIR 8'h07
`define AMGC_ADDR_DRIVE 8'h09
`define AMGC_ADDR_LEVEL 8'h0B
`define AMGC_ADDR_READBACK 8'h0D

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define AMGC_AVG_MSB 2
`define AMGC_POLICY_BIT 7
`define AMGC_MODE_MSB 6
`define AMGC_MODE_LSB 5
`define AMGC_OSC_BIT 4
`define AMGC_DIV_MSB 3
`define AMGC_MODE_AUTO 2'h1
`define AMGC_RESET_BYTE 8'h00
`define AMGC_ZERO_BYTE 8'h00
`define AMGC_ONES_BYTE 8'hFF
`define AMGC_AVG_PAD 5'h00

`endif

// file: verilog/amgc_pkg.sv
package amgc_pkg;

  typedef logic [7:0] amgc_byte_t;

  typedef enum logic [1:0] {
    AMGC_CONV_MANUAL = 2'b00,
    AMGC_CONV_AUTO = 2'b01,
    AMGC_CONV_RSVD2 = 2'b10,
    AMGC_CONV_RSVD3 = 2'b11
  } amgc_conv_e;

  // Configuration bank: writable registers plus pin synchronizers and read data
  typedef struct packed {
    logic [2:0] averagingCode;
    amgc_byte_t opMode;
    amgc_byte_t funcSel;
    amgc_byte_t dirSel;
    amgc_byte_t driveType;
    amgc_byte_t levelSet;
    amgc_byte_t pinSync1;
    amgc_byte_t pinSync2;
    amgc_byte_t readData;
  } amgc_state_s;

  // Per-channel pad controls
  typedef struct packed {
    amgc_byte_t padOut;
    amgc_byte_t padOe_b;
    amgc_byte_t analogSel;
  } amgc_pads_s;

endpackage : amgc_pkg

// file: verilog/amgc_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "amgc_consts.svh"

module amgc_config_regs #(
  parameter int CHANNELS = 8
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Register port from the serial front end
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // System controls
  input wire logic force_all_analog,
  input wire logic input_crc_error_flag,
  input wire logic hostConvStart,
  input wire logic autoConvTick,
  // Controls to the converter core
  output logic convStart,
  output logic sequencingPaused,
  output logic [2:0] averaging_code,
  output logic oscillator_select,
  output logic [3:0] sampleDivider,
  output logic divEnable,
  // Pads
  input wire logic [CHANNELS-1:0] padIn,
  output logic [CHANNELS-1:0] padOut,
  output logic [CHANNELS-1:0] padOe_b,
  output logic [CHANNELS-1:0] analogSel
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  amgc_pkg::amgc_state_s state_reg;
  amgc_pkg::amgc_state_s state_next;
  amgc_pkg::amgc_pads_s pads_reg;
  amgc_pkg::amgc_pads_s pads_next;

  amgc_pkg::amgc_conv_e convMode;
  logic crc_error_policy;
  logic errorHold;
  logic forceAnalog;
  logic [CHANNELS-1:0] gpioOut;
  logic [CHANNELS-1:0] driveLow;
  logic [CHANNELS-1:0] driveHigh;

  assign convMode = amgc_pkg::amgc_conv_e'(
    state_reg.opMode[`AMGC_MODE_MSB:`AMGC_MODE_LSB]);
  assign crc_error_policy = state_reg.opMode[`AMGC_POLICY_BIT];

  // ----------------------------------------
  // Error policy and override
  // ----------------------------------------
  // policy clear passes
  assign errorHold = crc_error_policy & input_crc_error_flag;
  assign forceAnalog = force_all_analog | errorHold;

  // ----------------------------------------
  // Per-channel pad logic
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gChan
      assign gpioOut[ch] = ~forceAnalog & state_reg.funcSel[ch] &
        state_reg.dirSel[ch];
      assign driveLow[ch] = gpioOut[ch] & ~state_reg.levelSet[ch];
      assign driveHigh[ch] = gpioOut[ch] & state_reg.levelSet[ch] &
        state_reg.driveType[ch];
    end
  endgenerate

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    pads_next = pads_reg;
    state_next.pinSync1 = amgc_pkg::amgc_byte_t'(padIn);
    state_next.pinSync2 = state_reg.pinSync1;
    if (regWrite) begin
      case (regAddr)
        `AMGC_ADDR_AVG: begin
          state_next.averagingCode = regWdata[`AMGC_AVG_MSB:0];
        end
        `AMGC_ADDR_OPMODE: begin
          state_next.opMode = regWdata;
        end
        `AMGC_ADDR_FUNC: begin
          state_next.funcSel = regWdata;
        end
        `AMGC_ADDR_DIR: begin
          state_next.dirSel = regWdata;
        end
        `AMGC_ADDR_DRIVE: begin
          state_next.driveType = regWdata;
        end
        `AMGC_ADDR_LEVEL: begin
          state_next.levelSet = regWdata;
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `AMGC_ADDR_AVG: begin
          state_next.readData = {`AMGC_AVG_PAD, state_reg.averagingCode};
        end
        `AMGC_ADDR_OPMODE: begin
          state_next.readData = state_reg.opMode;
        end
        `AMGC_ADDR_FUNC: begin
          state_next.readData = state_reg.funcSel;
        end
        `AMGC_ADDR_DIR: begin
          state_next.readData = state_reg.dirSel;
        end
        `AMGC_ADDR_DRIVE: begin
          state_next.readData = state_reg.driveType;
        end
        `AMGC_ADDR_LEVEL: begin
          state_next.readData = state_reg.levelSet;
        end
        `AMGC_ADDR_READBACK: begin
          state_next.readData = state_reg.pinSync2;
        end
        default: begin
          state_next.readData = `AMGC_ZERO_BYTE;
        end
      endcase
    end
    pads_next.padOut = amgc_pkg::amgc_byte_t'(driveHigh);
    pads_next.padOe_b = amgc_pkg::amgc_byte_t'(~(driveLow | driveHigh));
    pads_next.analogSel = forceAnalog ? `AMGC_ONES_BYTE : ~state_reg.funcSel;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= '0;
      pads_reg.padOut <= `AMGC_RESET_BYTE;
      pads_reg.padOe_b <= `AMGC_ONES_BYTE;
      pads_reg.analogSel <= `AMGC_ONES_BYTE;
    end else if (clkEn) begin
      state_reg <= state_next;
      pads_reg <= pads_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regRdata = state_reg.readData;
  assign averaging_code = state_reg.averagingCode;
  assign oscillator_select = state_reg.opMode[`AMGC_OSC_BIT];
  assign sampleDivider = state_reg.opMode[`AMGC_DIV_MSB:0];
  assign divEnable = (convMode == amgc_pkg::AMGC_CONV_AUTO);
  assign sequencingPaused = errorHold;
  assign convStart = ~errorHold & clkEn & (
    ((convMode == amgc_pkg::AMGC_CONV_MANUAL) & hostConvStart) |
    ((convMode == amgc_pkg::AMGC_CONV_AUTO) & autoConvTick));
  assign padOut = pads_reg.padOut[CHANNELS-1:0];
  assign padOe_b = pads_reg.padOe_b[CHANNELS-1:0];
  assign analogSel = pads_reg.analogSel[CHANNELS-1:0];

endmodule : amgc_config_regs
`default_nettype wire

// file: test/amgc_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module amgc_pad_model (
  // Pins
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe_b,
  input wire logic [7:0] extLevel,
  output logic [7:0] padIn
);
  assign padIn = (~padOe_b & padOut) | (padOe_b & extLevel);
endmodule : amgc_pad_model
`default_nettype wire

// file: test/amgc_config_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module amgc_config_regs_props #(
  parameter int CHANNELS = 8
) (
  // Watched ports
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic force_all_analog,
  input wire logic hostConvStart,
  input wire logic autoConvTick,
  input wire logic convStart,
  input wire logic sequencingPaused,
  input wire logic divEnable,
  input wire logic [CHANNELS-1:0] padIn,
  input wire logic [CHANNELS-1:0] padOe_b,
  input wire logic [CHANNELS-1:0] analogSel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic rd;
  logic ok;
  assign rd = regRead && clkEn;
  assign ok = rst_b && clkEn;
  avg_rsvd_zero_a: assert property (rd && regAddr == 8'h03 |=>
    regRdata[7:3] == 5'h00) else $error("reserved bits set");
  unmapped_zero_a: assert property (rd && regAddr == 8'h01 |=>
    regRdata == 8'h00) else $error("unmapped read nonzero");
  host_start_a: assert property (convStart && !divEnable |->
    hostConvStart) else $error("start without host");
  auto_start_a: assert property (convStart && divEnable |->
    autoConvTick) else $error("start without tick");
  crc_pause_a: assert property (sequencingPaused |->
    !convStart) else $error("start while paused");
  force_analog_a: assert property (force_all_analog && clkEn |=>
    analogSel == '1) else $error("channels not forced analog");
  analog_undriven_a: assert property (
    (analogSel & ~padOe_b) == '0) else $error("analog pin driven");
  pin_readback_a: assert property (rd && regAddr == 8'h0D && $past(ok, 2) &&
    $past(ok) |=> regRdata == $past(padIn, 3)) else $error("bad readback");
  freeze_no_start_a: assert property (!clkEn |-> !convStart)
    else $error("start while frozen");
endmodule : amgc_config_regs_props
bind amgc_config_regs amgc_config_regs_props #(.CHANNELS(CHANNELS))
  amgc_config_regs_props_i (
    .clock(clock),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .regRead(regRead),
    .regAddr(regAddr),
    .regRdata(regRdata),
    .force_all_analog(force_all_analog),
    .hostConvStart(hostConvStart),
    .autoConvTick(autoConvTick),
    .convStart(convStart),
    .sequencingPaused(sequencingPaused),
    .divEnable(divEnable),
    .padIn(padIn),
    .padOe_b(padOe_b),
    .analogSel(analogSel)
  );
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin nErrors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_top;
  logic clock = 1'b0, rst_b = 1'b0, clkEn = 1'b1, regWrite = 1'b0;
  logic regRead = 1'b0, rdPend = 1'b0, force_all_analog = 1'b0;
  logic input_crc_error_flag = 1'b0, hostConvStart = 1'b0;
  logic autoConvTick = 1'b0, convStart, sequencingPaused;
  logic oscillator_select, divEnable;
  logic [2:0] averaging_code;
  logic [3:0] sampleDivider;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, extLevel = 8'h00;
  logic [7:0] regRdata, padIn, padOut, padOe_b, analogSel;
  logic [7:0] f, d, o, lv, op, m;
  logic [2:0] av;
  logic [7:0] q[$];
  logic [7:0] addrs[6] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0B};
  int nErrors = 0, totalChecks = 0, seed = 32'h22817807;
  always #2 clock = ~clock;
  amgc_config_regs amgc_config_regs_i (.*);
  amgc_pad_model amgc_pad_model_i (.*);
  task automatic giveVerdict;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : giveVerdict
  task automatic wr(input logic [7:0] a, v);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = v;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    q.push_back(e);
    @(negedge clock);
    regRead = 1'b0;
  endtask : rd
  always @(posedge clock) rdPend <= regRead & clkEn;
  always @(negedge clock) if (rdPend) `CHK(regRdata, q.pop_front())
  initial begin
    #20000;
    nErrors++;
    giveVerdict;
  end
  initial begin
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    $display("test reset done");
    foreach (addrs[i]) begin
      o = $random(seed);
      if (i == 1) o[6] = 1'b0;
      wr(addrs[i], o);
      if (i == 0) av = o[2:0];
      if (i == 0) `CHK(averaging_code, av)
      rd(addrs[i], i == 0 ? o & 8'h07 : o);
    end
    rd(8'h01, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 40; k++) begin
      f = $random(seed);
      d = $random(seed);
      o = $random(seed);
      lv = $random(seed);
      op = $random(seed) & 8'hBF;
      extLevel = $random(seed);
      {force_all_analog, input_crc_error_flag} = $random(seed);
      {hostConvStart, autoConvTick} = $random(seed);
      wr(8'h05, f);
      wr(8'h07, d);
      wr(8'h09, o);
      wr(8'h0B, lv);
      wr(8'h04, op);
      wr(8'h0D, $random(seed));
      `CHK({oscillator_select, sampleDivider}, op[4:0])
      `CHK(divEnable, op[5])
      `CHK(sequencingPaused, op[7] & input_crc_error_flag)
      `CHK(convStart, ~(op[7] & input_crc_error_flag) & (op[5] ? autoConvTick : hostConvStart))
      if (k == 3) begin
        clkEn = 1'b0;
        #1;
        `CHK(convStart, 1'b0)
        wr(8'h03, {5'h00, ~av});
        `CHK(averaging_code, av)
        clkEn = 1'b1;
      end
      repeat (4) @(negedge clock);
      m = f & d & ~{8{force_all_analog | (op[7] & input_crc_error_flag)}};
      m = m & (o | ~lv);
      rd(8'h0D, (m & lv) | (~m & extLevel));
    end
    $display("test pads done");
    repeat (4) @(negedge clock);
    giveVerdict;
  end
endmodule : tb_top
`default_nettype wire
